/* File: nv_script_loader.sv */
/*
   Device end: staged and active register banks, update control, script area and the script walker
   that saves staged registers to nonvolatile storage or restores them from it.
   Assumes a host on cfg_link_if that keeps sel, wr, addr and wdata steady from before an sclk rising
   edge until after it, and a single-cycle loadStart pulse on the local clock.
*/
// What this block does
// - Update bit copies staged registers into active.
// - Copy happens on the following sclk rising edge.
// - Update bit clears itself after the copy.
// - Script lists start address and length per range.
// - Command byte with top bit zero means transfer.
// - Low seven bits hold length minus one.
// - Next two bytes hold start address, high first.
// - Top bit one means opcode: update or end.
// - Update opcode copies staged into active registers.
// - End opcode stops the walk and transfer.
// - Script programmer puts end opcode in last byte.
// - Reset script already saves and restores every staged register, up to 128.
// - Save bit starts save, clears when done.
// - Status flag reads one while transfer runs.
`timescale 1ns/1ps
module nv_script_loader
   import cfg_loader_pkg::*;
#(
   parameter int REG_COUNT = DEF_REG_COUNT,
   parameter int NV_SIZE = DEF_NV_BYTES
) (
   input wire logic clock,
   input wire logic rst,
   cfg_link_if.device link,
   input wire logic loadStart,
   output logic [REG_COUNT-1:0][7:0] activeRegs,
   output logic busy
);
   localparam int REGIDX_W = (REG_COUNT > 1) ? $clog2(REG_COUNT) : 1;
   localparam int NVPTR_W = (NV_SIZE > 1) ? $clog2(NV_SIZE) : 1;

   typedef enum logic [4:0] {
      W_IDLE = 5'b0_0001,
      W_CMD = 5'b0_0010,
      W_ADHI = 5'b0_0100,
      W_ADLO = 5'b0_1000,
      W_DATA = 5'b1_0000
   } walk_t;

   typedef struct packed {
      logic [2:0] sclkSync;
      logic sclkLvl;
      logic [REG_COUNT-1:0][7:0] staged;
      logic [REG_COUNT-1:0][7:0] active;
      logic [SCRIPT_BYTES-1:0][7:0] script;
      logic [NV_SIZE-1:0][7:0] nv;
      logic updPending;
      walk_t walk;
      logic saving;
      logic busy;
      logic [7:0] ptr;
      logic [6:0] left;
      logic [15:0] rangeAddr;
      logic [NVPTR_W-1:0] nvPtr;
      logic [7:0] rdata;
   } state_t;

   state_t s_r;
   state_t s_nxt;

   // One entry covering the whole staged bank, then an update, then end markers everywhere else.
   // A single entry only reaches 128 bytes, so larger banks need the script edited.
   function automatic logic [SCRIPT_BYTES-1:0][7:0] defaultScript();
      logic [SCRIPT_BYTES-1:0][7:0] sc;
      for (int i = 0; i < SCRIPT_BYTES; i++) begin
         sc[i] = OP_END;
      end
      sc[0] = {1'b0, 7'(REG_COUNT - 1)};
      sc[1] = 8'h00;
      sc[2] = 8'h00;
      sc[3] = OP_UPDATE;
      return sc;
   endfunction

   function automatic logic isStaged(input logic [15:0] a);
      return a < 16'(REG_COUNT);
   endfunction

   function automatic logic isScript(input logic [15:0] a);
      return (a >= SCRIPT_BASE) && (a <= SCRIPT_LAST);
   endfunction

   function automatic logic [7:0] regRead(input state_t st, input logic [15:0] a);
      logic [7:0] v;
      logic [15:0] off;
      v = 8'h00;
      off = a - SCRIPT_BASE;
      if (isStaged(a)) begin
         v = st.staged[a[REGIDX_W-1:0]];
      end else if (isScript(a)) begin
         v = st.script[off[7:0]];
      end else if (a == APPLY_OFFS) begin
         v[APPLY_BIT] = st.updPending;
      end else if (a == XFER_STATUS_OFFS) begin
         v[STATUS_BIT] = st.busy;
      end else if (a == SAVE_OFFS) begin
         v[SAVE_BIT] = st.saving;
      end
      return v;
   endfunction

   function automatic state_t resetState();
      state_t st;
      st = '0;
      st.script = defaultScript();
      st.walk = W_IDLE;
      st.updPending = APPLY_RESET;
      st.saving = SAVE_RESET;
      st.busy = STATUS_RESET;
      return st;
   endfunction

   always_comb begin
      logic rise;
      logic [7:0] cmd;
      logic [15:0] off;
      logic finish;
      rise = 1'b0;
      cmd = 8'h00;
      off = 16'h0000;
      finish = 1'b0;
      s_nxt = s_r;
      s_nxt.sclkSync = {s_r.sclkSync[1:0], link.sclk};
      // A level counts only once the second and third stages agree.
      if (s_r.sclkSync[1] == s_r.sclkSync[2]) begin
         s_nxt.sclkLvl = s_r.sclkSync[2];
         rise = s_r.sclkSync[2] & ~s_r.sclkLvl;
      end

      if (rise) begin
         if (s_r.updPending) begin
            s_nxt.active = s_r.staged;
            s_nxt.updPending = 1'b0;
         end
         if (link.sel) begin
            s_nxt.rdata = regRead(s_r, link.addr);
            if (link.wr) begin
               off = link.addr - SCRIPT_BASE;
               if (link.addr == APPLY_OFFS && link.wdata[APPLY_BIT]) begin
                  s_nxt.updPending = 1'b1;
               end
               // Staged registers and the script are frozen while a transfer runs so a save never captures a half-written set.
               if (!s_r.busy && isStaged(link.addr)) begin
                  s_nxt.staged[link.addr[REGIDX_W-1:0]] = link.wdata;
               end
               if (!s_r.busy && isScript(link.addr)) begin
                  s_nxt.script[off[7:0]] = link.wdata;
               end
               if (!s_r.busy && link.addr == SAVE_OFFS && link.wdata[SAVE_BIT]) begin
                  s_nxt.busy = 1'b1;
                  s_nxt.saving = 1'b1;
                  s_nxt.walk = W_CMD;
                  s_nxt.ptr = 8'h00;
                  s_nxt.nvPtr = '0;
               end
            end
         end
      end

      if (loadStart && !s_r.busy && !s_nxt.busy) begin
         s_nxt.busy = 1'b1;
         s_nxt.saving = 1'b0;
         s_nxt.walk = W_CMD;
         s_nxt.ptr = 8'h00;
         s_nxt.nvPtr = '0;
      end

      case (s_r.walk)
         W_IDLE: begin
         end
         W_CMD: begin
            cmd = s_r.script[s_r.ptr];
            s_nxt.ptr = s_r.ptr + 8'h01;
            if (!cmd[CMD_KIND_BIT]) begin
               s_nxt.left = cmd[6:0];
               s_nxt.walk = W_ADHI;
            end else if (cmd == OP_UPDATE) begin
               s_nxt.active = s_nxt.staged;
               finish = (s_r.ptr == 8'hFF);
            end else begin
               // Unknown opcodes stop the walk like an end marker rather than run off the area.
               finish = 1'b1;
            end
         end
         W_ADHI: begin
            s_nxt.rangeAddr[15:8] = s_r.script[s_r.ptr];
            s_nxt.ptr = s_r.ptr + 8'h01;
            s_nxt.walk = W_ADLO;
         end
         W_ADLO: begin
            s_nxt.rangeAddr[7:0] = s_r.script[s_r.ptr];
            s_nxt.ptr = s_r.ptr + 8'h01;
            s_nxt.walk = W_DATA;
         end
         W_DATA: begin
            // Unmapped addresses still use up a storage byte so the layout stays fixed.
            if (isStaged(s_r.rangeAddr)) begin
               if (s_r.saving) begin
                  s_nxt.nv[s_r.nvPtr] = s_r.staged[s_r.rangeAddr[REGIDX_W-1:0]];
               end else begin
                  s_nxt.staged[s_r.rangeAddr[REGIDX_W-1:0]] = s_r.nv[s_r.nvPtr];
               end
            end
            s_nxt.nvPtr = s_r.nvPtr + NVPTR_W'(1);
            s_nxt.rangeAddr = s_r.rangeAddr + 16'h0001;
            s_nxt.left = s_r.left - 7'h01;
            if (s_r.left == 7'h00) begin
               s_nxt.walk = W_CMD;
            end
         end
         default: begin
            finish = 1'b1;
         end
      endcase

      if (finish) begin
         s_nxt.walk = W_IDLE;
         s_nxt.busy = 1'b0;
         s_nxt.saving = 1'b0;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         s_r <= resetState();
      end else begin
         s_r <= s_nxt;
      end
   end

   assign activeRegs = s_r.active;
   assign busy = s_r.busy;
   assign link.rdata = s_r.rdata;
endmodule // nv_script_loader

/* File: cfg_loader_pkg.sv */
/*
   Shared constants for the staged-register update and script-driven save/restore block.
   Assumes both link ends and the testbench import this package.
*/
package cfg_loader_pkg;
   localparam int ADDR_W = 16;
   localparam int DATA_W = 8;
   localparam logic [15:0] APPLY_OFFS = 16'h0232;
   localparam logic [15:0] SCRIPT_BASE = 16'h0A00;
   localparam logic [15:0] SCRIPT_LAST = 16'h0AFF;
   localparam logic [15:0] XFER_STATUS_OFFS = 16'h0B00;
   localparam logic [15:0] SAVE_OFFS = 16'h0B03;
   localparam int SCRIPT_BYTES = int'(SCRIPT_LAST - SCRIPT_BASE) + 1;
   localparam int APPLY_BIT = 0;
   localparam int STATUS_BIT = 0;
   localparam int SAVE_BIT = 0;
   localparam int CMD_KIND_BIT = 7;
   localparam logic APPLY_RESET = 1'b0;
   localparam logic SAVE_RESET = 1'b0;
   localparam logic STATUS_RESET = 1'b0;
   localparam logic [7:0] OP_UPDATE = 8'h80;
   localparam logic [7:0] OP_END = 8'hFF;
   localparam int DEF_REG_COUNT = 32;
   localparam int DEF_NV_BYTES = 256;
   localparam int CLK_PERIOD_NS = 5;
   localparam int SCLK_HALF_NS = 40;
   localparam int SCLK_HALF_CYC = (SCLK_HALF_NS / CLK_PERIOD_NS < 1) ? 1 : SCLK_HALF_NS / CLK_PERIOD_NS;
endpackage

/* File: cfg_link_if.sv */
/*
   Serial register link between the host port and the device loader.
   Assumes the host makes the serial clock and holds address and data steady around its rising edge.
*/
`timescale 1ns/1ps
interface cfg_link_if;
   logic sclk;
   logic sel;
   logic wr;
   logic [15:0] addr;
   logic [7:0] wdata;
   logic [7:0] rdata;
   modport device (
      input sclk,
      input sel,
      input wr,
      input addr,
      input wdata,
      output rdata
   );
   modport host (
      output sclk,
      output sel,
      output wr,
      output addr,
      output wdata,
      input rdata
   );
endinterface

/* File: cfg_host_port.sv */
/*
   Host end: turns one user request at a time into a framed access on the serial link and
   returns the byte the device answers with.
   Assumes the device acts on the sclk rising edge well within one half period.
*/
`timescale 1ns/1ps
module cfg_host_port
   import cfg_loader_pkg::*;
#(
   parameter int HALF_CYC = SCLK_HALF_CYC
) (
   input wire logic clock,
   input wire logic rst,
   cfg_link_if.host link,
   input wire logic reqValid,
   input wire logic reqWrite,
   input wire logic [15:0] reqAddr,
   input wire logic [7:0] reqData,
   output logic reqReady,
   output logic rspValid,
   output logic [7:0] rspData
);
   typedef enum logic [3:0] {
      H_IDLE = 4'b0001,
      H_SETUP = 4'b0010,
      H_HIGH = 4'b0100,
      H_LOW = 4'b1000
   } host_t;

   typedef struct packed {
      host_t st;
      logic [15:0] cnt;
      logic sclk;
      logic sel;
      logic wr;
      logic [15:0] addr;
      logic [7:0] wdata;
      logic [2:0][7:0] rdSync;
      logic ready;
      logic rspValid;
      logic [7:0] rspData;
   } hstate_t;

   hstate_t h_r;
   hstate_t h_nxt;

   always_comb begin
      logic halfDone;
      halfDone = (h_r.cnt == 16'(HALF_CYC - 1));
      h_nxt = h_r;
      h_nxt.rdSync = {h_r.rdSync[1:0], link.rdata};
      h_nxt.rspValid = 1'b0;
      h_nxt.cnt = h_r.cnt + 16'h0001;
      case (h_r.st)
         H_IDLE: begin
            h_nxt.cnt = 16'h0000;
            if (reqValid && h_r.ready) begin
               h_nxt.ready = 1'b0;
               h_nxt.sel = 1'b1;
               h_nxt.wr = reqWrite;
               h_nxt.addr = reqAddr;
               h_nxt.wdata = reqData;
               h_nxt.st = H_SETUP;
            end
         end
         H_SETUP: begin
            if (halfDone) begin
               h_nxt.cnt = 16'h0000;
               h_nxt.sclk = 1'b1;
               h_nxt.st = H_HIGH;
            end
         end
         H_HIGH: begin
            if (halfDone) begin
               h_nxt.cnt = 16'h0000;
               h_nxt.sclk = 1'b0;
               h_nxt.st = H_LOW;
            end
         end
         H_LOW: begin
            // The answer has long settled by now, so the last synchroniser stage is taken as is.
            if (halfDone) begin
               h_nxt.cnt = 16'h0000;
               h_nxt.rspValid = 1'b1;
               h_nxt.rspData = h_r.rdSync[2];
               h_nxt.sel = 1'b0;
               h_nxt.wr = 1'b0;
               h_nxt.ready = 1'b1;
               h_nxt.st = H_IDLE;
            end
         end
         default: begin
            h_nxt.st = H_IDLE;
            h_nxt.ready = 1'b1;
         end
      endcase
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         h_r <= '0;
         h_r.st <= H_IDLE;
         h_r.ready <= 1'b1;
      end else begin
         h_r <= h_nxt;
      end
   end

   assign link.sclk = h_r.sclk;
   assign link.sel = h_r.sel;
   assign link.wr = h_r.wr;
   assign link.addr = h_r.addr;
   assign link.wdata = h_r.wdata;
   assign reqReady = h_r.ready;
   assign rspValid = h_r.rspValid;
   assign rspData = h_r.rspData;
endmodule // cfg_host_port

/* File: cfg_loader_monitor.sv */
/*
   Link checks between the host port and the script loader.
   Assumes a half period of eight clocks.
*/
`timescale 1ns/1ps
module cfg_loader_monitor (
   input wire logic clock,
   input wire logic rst,
   input wire logic sclk,
   input wire logic sel,
   input wire logic wr,
   input wire logic [15:0] addr,
   input wire logic [7:0] wdata,
   input wire logic [7:0] rdata,
   input wire logic busy
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (rst);
   sclk_framed_a: assert property (sclk |-> sel)
      else $error("sclk outside frame");
   sel_setup_a: assert property ($rose(sel) |-> !sclk [*8] ##1 sclk)
      else $error("sclk setup wrong");
   sclk_high_a: assert property ($rose(sclk) |-> sclk [*8] ##1 !sclk)
      else $error("sclk high time wrong");
   sel_hold_a: assert property ($fell(sclk) |-> sel [*8] ##1 !sel)
      else $error("frame hold wrong");
   req_steady_a: assert property (sel && $past(sel) |-> $stable({addr, wdata, wr}))
      else $error("request moved in frame");
   idle_write_a: assert property (!sel |-> !wr)
      else $error("write flag outside frame");
   answer_frame_a: assert property ($changed(rdata) |-> sel)
      else $error("answer changed outside frame");
   walk_min_a: assert property ($rose(busy) |-> busy [*4])
      else $error("walk too short");
   walk_end_a: assert property ($rose(busy) |-> ##[1:100] !busy)
      else $error("walk never ended");
   cover property ($rose(busy));
   cover property ($fell(sclk) && wr);
   cover property ($changed(rdata));
endmodule // cfg_loader_monitor

/* File: register_update_and_nv_script_bench.sv */
/*
   Bench joining the host port and the script loader over one link.
   Assumes default parameters: 32 staged registers, half period of eight clocks.
*/
`timescale 1ns/1ps
module register_update_and_nv_script_bench
   import cfg_loader_pkg::*;
;
   logic clock, rst, loadStart, reqValid, reqWrite, reqReady, rspValid, busy;
   logic [15:0] reqAddr;
   logic [7:0] reqData, rspData;
   logic [31:0][7:0] activeRegs;
   logic [7:0] stg[32], act[32], sav[32], q[$];
   logic [31:0] seed = 32'h0ccb;
   int errorCnt = 0;
   int nCompared = 0;
   cfg_link_if lnk();
   nv_script_loader nv_script_loader_inst (.clock(clock), .rst(rst), .link(lnk), .loadStart(loadStart),
      .activeRegs(activeRegs), .busy(busy));
   cfg_host_port cfg_host_port_inst (.clock(clock), .rst(rst), .link(lnk), .reqValid(reqValid),
      .reqWrite(reqWrite), .reqAddr(reqAddr), .reqData(reqData), .reqReady(reqReady),
      .rspValid(rspValid), .rspData(rspData));
   cfg_loader_monitor cfg_loader_monitor_inst (.clock(clock), .rst(rst), .sclk(lnk.sclk), .sel(lnk.sel),
      .wr(lnk.wr), .addr(lnk.addr), .wdata(lnk.wdata), .rdata(lnk.rdata), .busy(busy));
   function automatic logic [7:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[7:0];
   endfunction
   task automatic chk(input string n, input logic [7:0] e, g);
      nCompared++;
      if (g !== e) begin
         errorCnt++;
         $display("wrong value %s exp %h got %h", n, e, g);
      end
   endtask
   // A write answers with the byte held before it, so every access has a note.
   task automatic acc(input logic w, input logic [15:0] a, input logic [7:0] d, e);
      @(posedge clock);
      reqValid <= 1'b1;
      reqWrite <= w;
      reqAddr <= a;
      reqData <= d;
      q.push_back(e);
      do @(posedge clock); while (reqReady !== 1'b1);
      reqValid <= 1'b0;
   endtask
   task automatic drain();
      for (int i = 0; i < 60 && q.size() > 0; i++) @(posedge clock);
      chk("pending", 8'h00, 8'(q.size()));
   endtask
   task automatic chkAct();
      for (int i = 0; i < 32; i++) chk("activeRegs", act[i], activeRegs[i]);
   endtask
   task automatic walk();
      int c;
      c = 0;
      for (int i = 0; i < 80 && busy !== 1'b1; i++) @(posedge clock);
      while (busy === 1'b1 && c < 300) begin
         @(posedge clock);
         c++;
      end
      chk("busy", 8'h00, 8'(busy));
      chk("walkRan", 8'h01, 8'(c > 4));
   endtask
   // Writes still in flight would reach the loader while it walks and be refused, so let them land first.
   task automatic load();
      drain();
      @(posedge clock);
      loadStart <= 1'b1;
      @(posedge clock);
      loadStart <= 1'b0;
      walk();
   endtask
   task automatic giveVerdict();
      $display("compared %0d mismatches %0d", nCompared, errorCnt);
      if (errorCnt == 0 && nCompared > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   always @(posedge clock) begin
      if (rspValid === 1'b1) begin
         if (q.size() == 0) chk("spare", 8'h00, 8'hff);
         else chk("rspData", q.pop_front(), rspData);
      end
   end
   initial begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end
   initial begin
      #100000;
      errorCnt++;
      giveVerdict();
   end
   initial begin
      rst = 1'b1;
      loadStart = 1'b0;
      reqValid = 1'b0;
      reqWrite = 1'b0;
      reqAddr = 16'h0000;
      reqData = 8'h00;
      act = '{default: 8'h00};
      repeat (12) @(posedge clock);
      rst <= 1'b0;
      acc(0, APPLY_OFFS, 8'h00, 8'h00);
      acc(0, XFER_STATUS_OFFS, 8'h00, 8'h00);
      acc(0, SAVE_OFFS, 8'h00, 8'h00);
      acc(0, SCRIPT_BASE, 8'h00, 8'h1f);
      acc(0, SCRIPT_BASE + 16'h0003, 8'h00, OP_UPDATE);
      acc(0, SCRIPT_LAST, 8'h00, OP_END);
      acc(0, 16'h0100, 8'h00, 8'h00);
      drain();
      $display("reset values done");
      for (int i = 0; i < 32; i++) begin
         stg[i] = rnd();
         acc(1, 16'(i), stg[i], 8'h00);
      end
      acc(1, APPLY_OFFS, 8'h01, 8'h00);
      drain();
      chkAct();
      acc(0, APPLY_OFFS, 8'h00, 8'h01);
      acc(0, APPLY_OFFS, 8'h00, 8'h00);
      drain();
      act = stg;
      chkAct();
      $display("update done");
      sav = stg;
      acc(1, SAVE_OFFS, 8'h01, 8'h00);
      acc(0, XFER_STATUS_OFFS, 8'h00, 8'h01);
      walk();
      acc(0, SAVE_OFFS, 8'h00, 8'h00);
      acc(0, XFER_STATUS_OFFS, 8'h00, 8'h00);
      for (int i = 0; i < 32; i++) begin
         stg[i] = rnd();
         acc(1, 16'(i), stg[i], sav[i]);
      end
      // The new set goes to active first, so only the script's update code can bring the saved set back.
      acc(1, APPLY_OFFS, 8'h01, 8'h00);
      acc(0, APPLY_OFFS, 8'h00, 8'h01);
      drain();
      act = stg;
      chkAct();
      load();
      act = sav;
      chkAct();
      acc(0, 16'h001f, 8'h00, sav[31]);
      $display("save and restore done");
      // Range of two bytes at 4 ended by the stop code; register 6 differs so a stray copy to active would show.
      acc(1, SCRIPT_BASE, 8'h01, 8'h1f);
      acc(1, SCRIPT_BASE + 16'h0001, 8'h00, 8'h00);
      acc(1, SCRIPT_BASE + 16'h0002, 8'h04, 8'h00);
      acc(1, SCRIPT_BASE + 16'h0003, OP_END, OP_UPDATE);
      acc(1, SAVE_OFFS, 8'h01, 8'h00);
      walk();
      acc(1, 16'h0004, 8'h5a, sav[4]);
      acc(1, 16'h0005, 8'ha5, sav[5]);
      acc(1, 16'h0006, ~sav[6], sav[6]);
      load();
      drain();
      chkAct();
      acc(0, 16'h0004, 8'h00, sav[4]);
      acc(0, 16'h0005, 8'h00, sav[5]);
      acc(0, 16'h0006, 8'h00, ~sav[6]);
      drain();
      $display("script edit done");
      giveVerdict();
   end
endmodule // register_update_and_nv_script_bench
